/* src/hspd_core.sv */
// high-side pwm channel with dither, current loop and overvoltage cut
//
// How it works
// - channel runs open-loop pwm or closed-loop on measured current
// - period 10 to 1000 units of 100 us, duty in 0.1 % steps
// - dither rate is pwm rate over an even divider, at most 500 Hz
// - dither depth at most 50 %, duty plus or minus depth in 0..100 %
// - output off above overvoltage, resumes by itself when it drops
// - output shorted above supply shows as voltage-above-normal flag
// - return channel range is selectable, 0..1 A or 0..2 A
`timescale 1ns/100ps
`default_nettype none
`include "hspd_defs.svh"
module hspd_core #(
    parameter int P_TICK_CYC = `HSPD_TICK_CYC
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire hspd_pkg::hspd_cfg_s i_cfg,
    input wire logic [11:0] i_meas_ma,
    input wire logic i_ovp_pin,
    input wire logic i_above_pin,
    output var logic o_drive,
    output var logic o_period_pulse,
    output var logic o_ret_range_2a,
    output var hspd_pkg::hspd_stat_s o_status
);
    import hspd_pkg::*;

    localparam int STEP_RAW = P_TICK_CYC / `HSPD_DUTY_FULL;
    localparam int STEP_CYC = (STEP_RAW < 1) ? 1 : STEP_RAW;

    ////////////////////////////////////////////////////////////////////
    // helpers

    // clamp a signed duty into 0..1000
    function automatic logic [9:0] clamp_duty(input int v);
        int r;
        r = v;
        if (r < 0) begin
            r = 0;
        end
        if (r > `HSPD_DUTY_FULL) begin
            r = `HSPD_DUTY_FULL;
        end
        return r[9:0];
    endfunction

    // legality of a settings word; an illegal word is never adopted
    function automatic logic cfg_ok(input hspd_cfg_s c);
        int per;
        int dty;
        int dep;
        int div;
        int lim;
        logic ok;
        per = int'(c.period);
        dty = int'(c.duty);
        dep = int'(c.dith_depth);
        div = int'(c.dith_div);
        lim = c.range_2a ? `HSPD_RANGE_2A_MA : `HSPD_RANGE_1A_MA;
        ok = (per >= `HSPD_PER_MIN) && (per <= `HSPD_PER_MAX);
        ok = ok && (dty <= `HSPD_DUTY_FULL);
        if (div != 0) begin
            ok = ok && !c.dith_div[0];
            ok = ok && (per * div >= `HSPD_DITH_MIN_UNITS);
            ok = ok && (dep <= `HSPD_DEPTH_MAX);
            if (c.mode != HSPD_CURRENT) begin
                ok = ok && (dty >= dep);
                ok = ok && (dty + dep <= `HSPD_DUTY_FULL);
            end
        end
        ok = ok && (int'(c.setpoint_ma) <= lim);
        return ok;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // pins

    logic ovp;
    logic above;

    // both comparators come from the analog side, so they are synchronised
    hspd_sync #(
        .W(2)
    ) u_sync (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_pin({i_ovp_pin, i_above_pin}),
        .o_level({ovp, above})
    );

    ////////////////////////////////////////////////////////////////////
    // timebase: step -> duty slot -> period

    logic [15:0] stepc;
    logic [9:0] sub;
    logic [9:0] slot;
    hspd_cfg_s act;
    wire step_en = (int'(stepc) == STEP_CYC - 1);
    wire sub_last = (sub == act.period - 10'h001);
    wire slot_last = (slot == `HSPD_DUTY_LAST);
    wire bound = step_en && sub_last && slot_last;
    wire in_ok = cfg_ok(i_cfg);
    hspd_cfg_s next_act;

    // the word that runs from the coming boundary; an illegal one keeps act
    assign next_act = in_ok ? i_cfg : act;

    // one duty slot lasts period steps, so a period is 1000 slots
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            stepc <= 16'h0000;
            sub <= 10'h000;
            slot <= 10'h000;
        end else begin
            stepc <= step_en ? 16'h0000 : stepc + 16'h0001;
            if (step_en) begin
                sub <= sub_last ? 10'h000 : sub + 10'h001;
                if (sub_last) begin
                    slot <= slot_last ? 10'h000 : slot + 10'h001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // settings shadow, dither phase and current loop

    logic [7:0] dcnt;
    logic [9:0] loop_duty;
    logic cfg_err;
    wire [7:0] dcnt_inc = dcnt + 8'h01;
    // dither and loop follow the word about to run, not the one ending
    wire dwrap = (dcnt_inc >= next_act.dith_div);
    wire dith_up = (dcnt < {1'b0, next_act.dith_div[7:1]});
    wire loop_low = (i_meas_ma < next_act.setpoint_ma);
    wire loop_high = (i_meas_ma > next_act.setpoint_ma);

    // everything but cfg_err is swapped only at a boundary, so no pulse is cut short
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            act <= '{mode: HSPD_OFF, on_state: 1'b0,
                     period: `HSPD_RST_PERIOD, duty: 10'h000,
                     dith_div: 8'h00, dith_depth: 10'h000,
                     setpoint_ma: 12'h000, range_2a: 1'b0};
            dcnt <= 8'h00;
            loop_duty <= 10'h000;
            cfg_err <= 1'b0;
        end else begin
            cfg_err <= !in_ok;
            if (bound) begin
                act <= next_act;
                dcnt <= (next_act.dith_div == 8'h00 || dwrap) ? 8'h00
                        : dcnt_inc;
                // integral step of one slot per period against the feedback
                if (next_act.mode != HSPD_CURRENT) begin
                    loop_duty <= next_act.duty;
                end else if (loop_low && loop_duty < 10'd1000) begin
                    loop_duty <= loop_duty + 10'h001;
                end else if (loop_high && loop_duty != 10'h000) begin
                    loop_duty <= loop_duty - 10'h001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // effective duty and drive

    logic [9:0] duty_eff;
    logic next_drive;
    // taken from the word about to run, so a new duty starts with its period
    wire [9:0] base = (next_act.mode == HSPD_CURRENT) ? loop_duty
        : next_act.duty;
    wire dith_on = (next_act.dith_div != 8'h00);
    wire [9:0] dith_duty = dith_up
        ? clamp_duty(int'(base) + int'(next_act.dith_depth))
        : clamp_duty(int'(base) - int'(next_act.dith_depth));

    // duty is updated only at a boundary, keeping each period whole
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            duty_eff <= 10'h000;
        end else if (bound) begin
            duty_eff <= dith_on ? dith_duty : base;
        end
    end

    // the overvoltage cut acts at once and lifts when the pin drops
    always_comb begin
        unique case (act.mode)
            HSPD_OFF: next_drive = 1'b0;
            HSPD_ONOFF: next_drive = act.on_state;
            HSPD_PWM: next_drive = (slot < duty_eff);
            HSPD_CURRENT: next_drive = (slot < duty_eff);
        endcase
        if (ovp) begin
            next_drive = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_drive <= 1'b0;
            o_period_pulse <= 1'b0;
            o_ret_range_2a <= 1'b0;
            o_status <= '0;
        end else begin
            o_drive <= next_drive;
            o_period_pulse <= bound;
            o_ret_range_2a <= act.range_2a;
            o_status <= '{ovp_off: ovp, above_normal: above,
                           cfg_err: cfg_err, duty_now: duty_eff};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    logic [31:0] since;
    logic seen;

    // cycles since last boundary, for the period length check
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            since <= 32'h0000_0000;
            seen <= 1'b0;
        end else begin
            since <= bound ? 32'h0000_0000 : since + 32'h0000_0001;
            seen <= seen | bound;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);

    chk_ovp_cuts_drive: assert property (ovp |=> !o_drive)
        else $error("drive on during overvoltage");
    chk_period_length: assert property (bound && seen |->
        since + 32'd1 == 32'(int'(act.period) * 1000 * STEP_CYC))
        else $error("pwm period length wrong");
    chk_cfg_held: assert property (!bound |=> $stable(act))
        else $error("settings changed inside a period");
    chk_duty_bounds: assert property (duty_eff <= 10'd1000)
        else $error("effective duty out of range");
    chk_dither_div: assert property (bound && act.dith_div != 8'h00
        |-> !act.dith_div[0] && int'(act.period) * int'(act.dith_div) >= 20)
        else $error("dither divider illegal");
    chk_loop_rises: assert property (bound
        && next_act.mode == HSPD_CURRENT && loop_low && loop_duty < 10'd1000
        |=> loop_duty == $past(loop_duty) + 10'h001)
        else $error("current loop did not raise duty");
    chk_onoff_level: assert property (act.mode == HSPD_ONOFF && !ovp
        |=> o_drive == $past(act.on_state))
        else $error("on/off level not driven");
    chk_above_flag: assert property ($rose(above)
        |=> o_status.above_normal)
        else $error("above-normal flag missed");
    chk_range_follow: assert property (bound ##1 1'b1
        |=> o_ret_range_2a == $past(act.range_2a))
        else $error("return range not applied");
endmodule
`default_nettype wire

/* shared/hspd_defs.svh */
// timing, limits and reset values of the high-side pwm channel
`ifndef HSPD_DEFS_SVH
`define HSPD_DEFS_SVH
`define HSPD_CLK_NS 32'hA
`define HSPD_TICK_NS 32'h186A0
`define HSPD_TICK_CYC (`HSPD_TICK_NS / `HSPD_CLK_NS)
`define HSPD_DUTY_FULL 1000
`define HSPD_DUTY_LAST 10'h3E7
`define HSPD_DEPTH_MAX 500
`define HSPD_PWM_FMIN_HZ 10
`define HSPD_PWM_FMAX_HZ 1000
`define HSPD_DITH_FMAX_HZ 500
`define HSPD_PER_MIN (1000000000 / (`HSPD_PWM_FMAX_HZ * 100000))
`define HSPD_PER_MAX (1000000000 / (`HSPD_PWM_FMIN_HZ * 100000))
`define HSPD_DITH_MIN_UNITS (1000000000 / (`HSPD_DITH_FMAX_HZ * 100000))
`define HSPD_RANGE_1A_MA 1000
`define HSPD_RANGE_2A_MA 2000
`define HSPD_RST_PERIOD 10'h00A
`endif

/* shared/hspd_pkg.sv */
// types of the high-side pwm channel
`default_nettype none
package hspd_pkg;
    typedef enum logic [1:0] {
        HSPD_OFF,
        HSPD_ONOFF,
        HSPD_PWM,
        HSPD_CURRENT
    } hspd_mode_e;

    typedef struct packed {
        hspd_mode_e mode;
        logic on_state;
        logic [9:0] period;
        logic [9:0] duty;
        logic [7:0] dith_div;
        logic [9:0] dith_depth;
        logic [11:0] setpoint_ma;
        logic range_2a;
    } hspd_cfg_s;

    typedef struct packed {
        logic ovp_off;
        logic above_normal;
        logic cfg_err;
        logic [9:0] duty_now;
    } hspd_stat_s;
endpackage
`default_nettype wire

/* src/hspd_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module hspd_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [W-1:0] i_pin,
    output var logic [W-1:0] o_level
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
    logic [W-1:0] agree;

    // only stage two reads stage one
    assign agree = ~(s2 ^ s3);

    // a change is taken once stages two and three agree
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            level <= '0;
        end else begin
            s1 <= i_pin;
            s2 <= s1;
            s3 <= s2;
            level <= (agree & s3) | (~agree & level);
        end
    end

    assign o_level = level;
endmodule
`default_nettype wire

/* src/hspd_unused_placeholder_none.sv */
// intentionally empty compilation unit
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

/* verification/hspd_load.sv */
// load and return-current sensor model facing the high-side output
`timescale 1ns/100ps
`default_nettype none
module hspd_load #(
    parameter int P_DIV = 10
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_drive,
    input wire logic i_period_pulse,
    input wire logic i_range_2a,
    output var logic [11:0] o_meas_ma,
    output var logic [31:0] o_on_cnt
);
    logic [31:0] cnt;
    int ma;
    ////////////////////////////////////////////////////////////////////////
    // one load per channel, never paralleled while pulsing
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt <= 32'h0;
            o_on_cnt <= 32'h0;
        end else if (i_period_pulse) begin
            cnt <= {31'h0, i_drive};
            o_on_cnt <= cnt;
        end else begin
            cnt <= cnt + {31'h0, i_drive};
        end
    end
    // return channel reads averaged coil current, paired with output
    assign ma = int'(o_on_cnt / P_DIV);
    // sensor saturates at 1000 mA on the 1 A scale only; on the 2 A scale the loop sees the full reading
    assign o_meas_ma = (!i_range_2a && ma > 1000) ? 12'h3E8 : 12'(ma);
endmodule
`default_nettype wire

/* verification/high_side_pwm_dither_output_tb.sv */
// self-checking bench of the high-side pwm channel
`timescale 1ns/100ps
`default_nettype none
module high_side_pwm_dither_output_tb;
    import hspd_pkg::*;
    localparam int P = 10; // shortest period keeps the run short
    logic i_clk, i_arst_n, i_ovp_pin, i_above_pin, drive, pulse, r2a;
    hspd_cfg_s i_cfg, g, bad [6];
    hspd_stat_s st;
    logic [11:0] meas;
    logic [31:0] on_cnt, lfsr;
    int fails, n_compared, cur, prev, d1, rd, dd;
    hspd_core #(.P_TICK_CYC(1000)) dut (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .i_cfg(i_cfg), .i_meas_ma(meas), .i_ovp_pin(i_ovp_pin),
        .i_above_pin(i_above_pin), .o_drive(drive),
        .o_period_pulse(pulse), .o_ret_range_2a(r2a), .o_status(st));
    hspd_load #(.P_DIV(P)) load (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .i_drive(drive), .i_period_pulse(pulse), .i_range_2a(r2a),
        .o_meas_ma(meas), .o_on_cnt(on_cnt));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    function automatic hspd_cfg_s mk(hspd_mode_e m, int pr, int d, int dv,
        int dp, int sp, logic r);
        mk = '{m, 1'b0, 10'(pr), 10'(d), 8'(dv), 10'(dp), 12'(sp), r};
    endfunction
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        lfsr_next = {1'b0, x[31:1]} ^ (x[0] ? 32'hA3000000 : 32'h0);
    endfunction
    task automatic cmp_num(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        cmp_num({31'h0, got}, {31'h0, exp});
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // wait for a period start, check it, then hand over the next settings
    // (-1 marks a period whose figure the model cannot foresee)
    task automatic next_per(input hspd_cfg_s c, input int nxt);
        int k;
        k = 0;
        do begin
            @(negedge i_clk);
            k++;
        end while (pulse !== 1'b1 && k < 12000);
        if (k >= 12000) begin
            fails++;
            end_of_test();
        end
        @(negedge i_clk);
        if (cur >= 0) cmp_num(32'(st.duty_now), 32'(cur));
        if (prev >= 0) cmp_num(on_cnt, 32'(prev * P));
        prev = cur;
        cur = nxt;
        i_cfg = c;
        $display("period test done at %0t", $time);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        fails = 0;
        n_compared = 0;
        prev = -1;
        cur = 300;
        lfsr = 32'hBF3F71CC;
        i_ovp_pin = 1'b0;
        i_above_pin = 1'b0;
        i_cfg = mk(HSPD_PWM, P, 300, 0, 0, 0, 1'b0);
        i_arst_n = 1'b0;
        repeat (3) @(negedge i_clk);
        i_arst_n = 1'b1;
        lfsr = lfsr_next(lfsr);
        rd = int'(lfsr % 32'h3E9);
        next_per(mk(HSPD_PWM, P, rd, 0, 0, 0, 1'b0), rd);
        g = mk(HSPD_PWM, P, 1000, 0, 0, 0, 1'b0);
        next_per(g, 1000);
        cmp_flag(r2a, 1'b0);
        // refused words: each must flag and leave the running period alone
        bad[0] = mk(HSPD_PWM, 9, 500, 0, 0, 0, 1'b0);
        bad[1] = mk(HSPD_PWM, 1001, 500, 0, 0, 0, 1'b0);
        bad[2] = mk(HSPD_PWM, P, 1001, 0, 0, 0, 1'b0);
        bad[3] = mk(HSPD_PWM, P, 500, 3, 100, 0, 1'b0);
        bad[4] = mk(HSPD_PWM, P, 500, 2, 501, 0, 1'b0);
        bad[5] = mk(HSPD_PWM, P, 100, 2, 200, 0, 1'b0);
        foreach (bad[i]) begin
            i_cfg = bad[i];
            repeat (2) @(negedge i_clk);
            cmp_flag(st.cfg_err, 1'b1);
        end
        i_cfg = g;
        repeat (2) @(negedge i_clk);
        cmp_flag(st.cfg_err, 1'b0);
        $display("refusal test done at %0t", $time);
        i_above_pin = 1'b1;
        repeat (6) @(negedge i_clk);
        cmp_flag(st.above_normal, 1'b1);
        // fault pin dropped again, and the above-normal flag must clear with it
        i_above_pin = 1'b0;
        repeat (6) @(negedge i_clk);
        cmp_flag(st.above_normal, 1'b0);
        next_per(mk(HSPD_PWM, P, 500, 2, 100, 0, 1'b0), -1);
        repeat (100) @(negedge i_clk);
        cmp_flag(drive, 1'b1);
        i_ovp_pin = 1'b1;
        repeat (6) @(negedge i_clk);
        cmp_flag(drive, 1'b0);
        cmp_flag(st.ovp_off, 1'b1);
        i_ovp_pin = 1'b0;
        repeat (6) @(negedge i_clk);
        cmp_flag(drive, 1'b1);
        cmp_flag(st.ovp_off, 1'b0);
        $display("pin test done at %0t", $time);
        prev = -1;
        next_per(mk(HSPD_PWM, P, 500, 2, 100, 0, 1'b0), -1);
        d1 = int'(st.duty_now);
        g = mk(HSPD_CURRENT, P, 100, 0, 0, 900, 1'b1);
        next_per(g, -1);
        dd = d1 - int'(st.duty_now);
        cmp_num(32'(d1 + int'(st.duty_now)), 32'h3E8);
        cmp_num(32'(dd < 0 ? -dd : dd), 32'hC8);
        next_per(g, -1);
        next_per(g, -1);
        d1 = int'(st.duty_now);
        cmp_flag(r2a, 1'b1);
        // an on/off word rides in here and is adopted at the next boundary
        g.mode = HSPD_ONOFF;
        g.on_state = 1'b1;
        g.duty = 10'h000;
        next_per(g, -1);
        cmp_num(32'(int'(st.duty_now) - d1), 32'h1);
        next_per(g, -1);
        repeat (3) @(negedge i_clk);
        cmp_num(32'(st.duty_now), 32'h0);
        cmp_flag(drive, 1'b1);
        $display("on/off test done at %0t", $time);
        end_of_test();
    end
endmodule
`default_nettype wire
